// ---- common/kipc_pkg.sv ----
package kipc_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_KEYS = 14;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 32;
    localparam int CNT_W = 11;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [31:0] ADDR_SETUP_BASE = 32'hFFFF_F360;
    localparam logic [31:0] ADDR_SETUP_LAST = 32'hFFFF_F36D;
    localparam logic [31:0] ADDR_CTRL = 32'hFFFF_F371;
    localparam logic [31:0] ADDR_STATUS = 32'hFFFF_F372;
    localparam logic [31:0] ADDR_LSCTRL = 32'hFFFF_F373;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int SETUP_EN_BIT = 0;
    localparam int SETUP_COND_LSB = 4;
    localparam logic [7:0] SETUP_RESET = 8'h20;
    localparam logic [7:0] SETUP_WMASK = 8'h31;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int LSCTRL_RUN_BIT = 0;
    localparam logic [7:0] LSCTRL_RESET = 8'h01;
    localparam int STAT_WINDOW_BIT = 0;
    localparam int STAT_DYN_BIT = 1;
    localparam int STAT_LEVEL_BIT = 2;
    localparam int STAT_LSRUN_BIT = 3;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int LOW_SPEED_HZ = 32_768;
    localparam int LS_DIV = CLK_HZ / LOW_SPEED_HZ;
    localparam logic [10:0] LS_DIV_LAST = 11'(LS_DIV - 1);
    localparam logic [CNT_W-1:0] WIN_CYC_0 = 11'h004;
    localparam logic [CNT_W-1:0] WIN_CYC_1 = 11'h008;
    localparam logic [CNT_W-1:0] WIN_CYC_2 = 11'h010;
    localparam logic [CNT_W-1:0] WIN_CYC_3 = 11'h020;
    localparam logic [CNT_W-1:0] INT_CYC_0 = 11'h080;
    localparam logic [CNT_W-1:0] INT_CYC_1 = 11'h100;
    localparam logic [CNT_W-1:0] INT_CYC_2 = 11'h200;
    localparam logic [CNT_W-1:0] INT_CYC_3 = 11'h400;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] reserved;
        logic [1:0] intervalSel;
        logic [1:0] windowSel;
        logic dynSel;
        logic pullEn;
    } kipc_ctrl_s;

    typedef enum logic [1:0] {
        COND_LOW = 2'h0,
        COND_HIGH = 2'h1,
        COND_FALL = 2'h2,
        COND_RISE = 2'h3
    } kipc_cond_e;

    typedef enum logic [2:0] {
        DYN_IDLE = 3'h1,
        DYN_WINDOW = 3'h2,
        DYN_GAP = 3'h4
    } kipc_dyn_e;

    // ------------------------------------------------------------
    // Timing decode
    // ------------------------------------------------------------
    function automatic logic [CNT_W-1:0] windowCycles(input logic [1:0] sel);
        case (sel)
            2'h0: windowCycles = WIN_CYC_0;
            2'h1: windowCycles = WIN_CYC_1;
            2'h2: windowCycles = WIN_CYC_2;
            default: windowCycles = WIN_CYC_3;
        endcase
    endfunction

    function automatic logic [CNT_W-1:0] intervalCycles(input logic [1:0] sel);
        case (sel)
            2'h0: intervalCycles = INT_CYC_0;
            2'h1: intervalCycles = INT_CYC_1;
            2'h2: intervalCycles = INT_CYC_2;
            default: intervalCycles = INT_CYC_3;
        endcase
    endfunction

endpackage

// ---- core/kipc_dyn_timer.sv ----
`timescale 1ns/10ps
module kipc_dyn_timer
    import kipc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic lsTick,
    input wire logic [1:0] windowSel,
    input wire logic [1:0] intervalSel,
    output logic windowOn,
    output logic samplePulse
);

    // ------------------------------------------------------------
    // Period decode
    // ------------------------------------------------------------
    kipc_dyn_e state_q;
    kipc_dyn_e state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic samplePulse_d;
    wire logic [CNT_W-1:0] winLen = windowCycles(windowSel);
    wire logic [CNT_W-1:0] intLen = intervalCycles(intervalSel);
    wire logic [CNT_W-1:0] cntNext = cnt_q + 11'h001;
    wire logic atIntervalEnd = (cntNext == intLen);
    wire logic atWindowEnd = (cntNext == winLen);
    // Sample at the tick that opens the last fs cycle of the window
    wire logic atSamplePoint = (cntNext == winLen - 11'h001);

    // ------------------------------------------------------------
    // Window and interval sequencing
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        samplePulse_d = 1'b0;
        case (state_q)
            DYN_IDLE: begin
                cnt_d = '0;
                if (run) begin
                    state_d = DYN_WINDOW;
                end
            end
            DYN_WINDOW: begin
                if (!run) begin
                    state_d = DYN_IDLE;
                end else if (lsTick) begin
                    cnt_d = cntNext;
                    samplePulse_d = atSamplePoint;
                    if (atWindowEnd) begin
                        state_d = DYN_GAP;
                    end
                end
            end
            DYN_GAP: begin
                if (!run) begin
                    state_d = DYN_IDLE;
                end else if (lsTick) begin
                    cnt_d = cntNext;
                    if (atIntervalEnd) begin
                        cnt_d = '0;
                        state_d = DYN_WINDOW;
                    end
                end
            end
            default: begin
                state_d = DYN_IDLE;
                cnt_d = '0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= DYN_IDLE;
            cnt_q <= '0;
            samplePulse <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            samplePulse <= samplePulse_d;
        end
    end

    assign windowOn = (state_q == DYN_WINDOW);

endmodule

// ---- core/kipc_top.sv ----
`timescale 1ns/10ps
// Functional notes
// - Pull-up enable set pulls up all enabled key inputs together as one group.
// - A key with its input enable clear is never pulled up.
// - Dynamic select clear holds pull-ups on; set pulses them in windows.
// - Window code 00/01/10/11 gives 4/8/16/32 low-speed clock cycles.
// - Interval code 00/01/10/11 gives 128/256/512/1024 low-speed clock cycles.
// - Dynamic mode samples one fs cycle before window end; edges only.
module kipc_top
    import kipc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DATA_W-1:0] regRdData,
    input wire logic [NUM_KEYS-1:0] keyIn,
    output logic [NUM_KEYS-1:0] keyPullupEn,
    output logic [NUM_KEYS-1:0] keySampled,
    output logic keySampleStrobe,
    output logic levelCondConflict
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    kipc_ctrl_s ctrl_q;
    logic [DATA_W-1:0] setup_q [NUM_KEYS];
    logic lsRun_q;
    logic [DATA_W-1:0] regRdData_d;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire logic hitCtrl = (regAddr == ADDR_CTRL);
    wire logic hitStatus = (regAddr == ADDR_STATUS);
    wire logic hitLsCtrl = (regAddr == ADDR_LSCTRL);
    wire logic hitSetup = (regAddr >= ADDR_SETUP_BASE) && (regAddr <= ADDR_SETUP_LAST);
    wire logic [31:0] setupOffset = regAddr - ADDR_SETUP_BASE;
    wire logic [3:0] setupIdx = setupOffset[3:0];
    wire logic wrCtrl = regWr && hitCtrl;
    wire logic wrLsCtrl = regWr && hitLsCtrl;
    wire logic wrSetup = regWr && hitSetup;

    // ------------------------------------------------------------
    // Field views
    // ------------------------------------------------------------
    logic [NUM_KEYS-1:0] keyEnable;
    logic [NUM_KEYS-1:0] keyLevelCond;
    wire logic dynMode = ctrl_q.pullEn && ctrl_q.dynSel;

    always_comb begin
        for (int i = 0; i < NUM_KEYS; i++) begin
            keyEnable[i] = setup_q[i][SETUP_EN_BIT];
            // Codes 00 and 01 are level conditions
            keyLevelCond[i] = !setup_q[i][SETUP_COND_LSB + 1];
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q <= kipc_ctrl_s'(CTRL_RESET);
        end else if (wrCtrl) begin
            ctrl_q <= kipc_ctrl_s'(regWrData);
        end
    end

    // ------------------------------------------------------------
    // Low-speed clock run control
    // ------------------------------------------------------------
    // Stopping fs freezes the dynamic window; keys then go undetected
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lsRun_q <= LSCTRL_RESET[LSCTRL_RUN_BIT];
        end else if (wrLsCtrl) begin
            lsRun_q <= regWrData[LSCTRL_RUN_BIT];
        end
    end

    // ------------------------------------------------------------
    // Per-key setup registers
    // ------------------------------------------------------------
    // Only the enable and condition fields are stored; the rest read zero
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_KEYS; i++) begin
                setup_q[i] <= SETUP_RESET;
            end
        end else if (wrSetup) begin
            setup_q[setupIdx] <= regWrData & SETUP_WMASK;
        end
    end

    // ------------------------------------------------------------
    // Low-speed clock divider
    // ------------------------------------------------------------
    logic [10:0] lsDiv_q;
    logic lsTick_q;
    wire logic lsDivWrap = (lsDiv_q == LS_DIV_LAST);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lsDiv_q <= '0;
            lsTick_q <= 1'b0;
        end else if (!lsRun_q) begin
            lsDiv_q <= '0;
            lsTick_q <= 1'b0;
        end else begin
            lsDiv_q <= lsDivWrap ? 11'h000 : lsDiv_q + 11'h001;
            lsTick_q <= lsDivWrap;
        end
    end

    // ------------------------------------------------------------
    // Dynamic pull-up generator
    // ------------------------------------------------------------
    logic windowOn;
    logic samplePulse;

    kipc_dyn_timer u_dyn_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(dynMode),
        .lsTick(lsTick_q),
        .windowSel(ctrl_q.windowSel),
        .intervalSel(ctrl_q.intervalSel),
        .windowOn(windowOn),
        .samplePulse(samplePulse)
    );

    // ------------------------------------------------------------
    // Pull-up drive
    // ------------------------------------------------------------
    // Static mode pulls up continuously; dynamic only inside the window
    wire logic pullPhase = !ctrl_q.dynSel || windowOn;
    wire logic groupPull = ctrl_q.pullEn && pullPhase;
    wire logic [NUM_KEYS-1:0] pullup_d = {NUM_KEYS{groupPull}} & keyEnable;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            keyPullupEn <= '0;
        end else begin
            keyPullupEn <= pullup_d;
        end
    end

    // ------------------------------------------------------------
    // Key sampling
    // ------------------------------------------------------------
    // Static and no-pull modes monitor every cycle; dynamic only at the
    // sample point, since outside the window the pin may float
    wire logic sampleNow = dynMode ? samplePulse : 1'b1;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            keySampled <= '0;
            keySampleStrobe <= 1'b0;
        end else begin
            keySampleStrobe <= sampleNow;
            if (sampleNow) begin
                keySampled <= keyIn & keyEnable;
            end
        end
    end

    // ------------------------------------------------------------
    // Level-condition check
    // ------------------------------------------------------------
    // Dynamic mode handles edges only; flag any enabled level condition
    wire logic levelConflict_d = dynMode && |(keyLevelCond & keyEnable);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            levelCondConflict <= 1'b0;
        end else begin
            levelCondConflict <= levelConflict_d;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    wire logic [DATA_W-1:0] statusWord = {
        4'h0,
        lsRun_q,
        levelConflict_d,
        dynMode,
        windowOn
    };

    always_comb begin
        regRdData_d = READ_UNMAPPED;
        if (hitCtrl) begin
            regRdData_d = ctrl_q;
        end else if (hitStatus) begin
            regRdData_d = statusWord;
        end else if (hitLsCtrl) begin
            regRdData_d = {7'h00, lsRun_q};
        end else if (hitSetup) begin
            regRdData_d = setup_q[setupIdx];
        end
    end

    // Data stand only in the cycle after the strobe
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            regRdData <= '0;
        end else if (regRd) begin
            regRdData <= regRdData_d;
        end else begin
            regRdData <= '0;
        end
    end

endmodule

// ---- test/kipc_top_asserts.sv ----
`timescale 1ns/10ps
module kipc_top_asserts
    import kipc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [DATA_W-1:0] regRdData,
    input wire logic [NUM_KEYS-1:0] keyIn,
    input wire logic [NUM_KEYS-1:0] keyPullupEn,
    input wire logic [NUM_KEYS-1:0] keySampled,
    input wire logic keySampleStrobe,
    input wire logic levelCondConflict
);
    // ------------------------------------------------------------
    // Shadow of the bus writes
    // ------------------------------------------------------------
    logic [NUM_KEYS-1:0] shEn_q;
    logic [7:0] shCtrl_q;
    logic [31:0] winCnt_q;
    wire hitSetup = regAddr >= ADDR_SETUP_BASE && regAddr <= ADDR_SETUP_LAST;
    wire unmapped = !hitSetup && regAddr != ADDR_CTRL && regAddr != ADDR_STATUS && regAddr != ADDR_LSCTRL;
    wire dynOn = shCtrl_q[0] & shCtrl_q[1];
    wire [NUM_KEYS-1:0] expPull = shCtrl_q[0] ? shEn_q : '0;
    // Slack of a few cycles covers the register stages behind the window
    wire [31:0] winLimit = 32'((32'h4 << shCtrl_q[3:2]) * LS_DIV + 4);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            shEn_q <= '0;
            shCtrl_q <= CTRL_RESET;
            winCnt_q <= '0;
        end else begin
            if (regWr && hitSetup) shEn_q[regAddr[3:0]] <= regWrData[0];
            if (regWr && regAddr == ADDR_CTRL) shCtrl_q <= regWrData;
            winCnt_q <= (dynOn && |keyPullupEn) ? winCnt_q + 32'h1 : 32'h0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence sCfgSteady;
        shCtrl_q == $past(shCtrl_q) && shCtrl_q == $past(shCtrl_q, 2) && shEn_q == $past(shEn_q, 2)
            && !$past(sys_rst) && !$past(sys_rst, 2);
    endsequence
    sequence sRdCtrl;
        regRd && regAddr == ADDR_CTRL;
    endsequence

    a_static_pull_group: assert property (sCfgSteady ##0 !shCtrl_q[1] |-> keyPullupEn == expPull)
        else $error("static pull-up differs from enables");
    a_no_stray_pull: assert property ((keyPullupEn & ~shEn_q & ~$past(shEn_q)) == '0)
        else $error("disabled key pulled up");
    a_static_strobe_on: assert property (sCfgSteady ##0 !dynOn |-> keySampleStrobe)
        else $error("strobe low outside dynamic mode");
    a_static_sample_val: assert property (sCfgSteady ##0 !dynOn && keyIn == $past(keyIn, 3)
        && keyIn == $past(keyIn) |-> keySampled == (keyIn & shEn_q))
        else $error("static sample differs");
    a_dyn_strobe_pulse: assert property (sCfgSteady ##0 dynOn && keySampleStrobe |=> !keySampleStrobe)
        else $error("dynamic strobe longer than one cycle");
    a_window_len_bound: assert property (dynOn |-> winCnt_q <= winLimit)
        else $error("pull-up window too long");
    a_read_ctrl_val: assert property (sRdCtrl |=> regRdData == $past(shCtrl_q))
        else $error("control readback wrong");
    a_read_idle_zero: assert property (!regRd |=> regRdData == 8'h00)
        else $error("read data outside read cycle");
    a_read_unmapped_zero: assert property (regRd && unmapped |=> regRdData == READ_UNMAPPED)
        else $error("unmapped read not zero");
endmodule

bind kipc_top kipc_top_asserts u_chk (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .keyIn(keyIn), .keyPullupEn(keyPullupEn),
    .keySampled(keySampled), .keySampleStrobe(keySampleStrobe), .levelCondConflict(levelCondConflict));

// ---- test/kipc_top_tb_top.sv ----
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin nChecks++; if ((got) !== (exp)) begin miscompares++; \
    $display("[FAIL] %s exp %h got %h", nm, exp, got); end end
module kipc_top_tb_top
    import kipc_pkg::*;
;
    logic clk, rst, regWr, regRd, keySampleStrobe, levelCondConflict;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWrData, regRdData, cfg;
    logic [NUM_KEYS-1:0] keyIn, keyPullupEn, keySampled, en, orAcc;
    int miscompares = 0;
    int nChecks = 0;
    int len, last, strobes, win;

    kipc_top DUT (.clk(clk), .sys_rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .keyIn(keyIn), .keyPullupEn(keyPullupEn),
        .keySampled(keySampled), .keySampleStrobe(keySampleStrobe), .levelCondConflict(levelCondConflict));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, input logic [7:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        `CHK("regRdData", exp, regRdData)
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic results();
        if (miscompares == 0 && nChecks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    // Four windows, their gaps and the frozen-clock check take about 84k cycles
    initial begin
        repeat (95000) @(posedge clk);
        miscompares++;
        results();
    end

    initial begin
        rst = 1'b1;
        regAddr = '0;
        regWrData = '0;
        regWr = 1'b0;
        regRd = 1'b0;
        keyIn = 14'h2A55;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(ADDR_CTRL, CTRL_RESET);
        rd(ADDR_LSCTRL, LSCTRL_RESET);
        for (int k = 0; k < NUM_KEYS; k++) rd(ADDR_SETUP_BASE + 32'(k), SETUP_RESET);
        wr(ADDR_SETUP_BASE, 8'hFF);
        rd(ADDR_SETUP_BASE, SETUP_WMASK);
        wr(32'hFFFF_F36E, 8'hFF);
        rd(32'hFFFF_F36E, READ_UNMAPPED);
        wr(ADDR_CTRL, 8'h01);
        wr(ADDR_SETUP_BASE + 32'd5, 8'h21);
        settle();
        wr(ADDR_SETUP_BASE + 32'd13, 8'h21);
        settle();
        wr(ADDR_SETUP_BASE + 32'd13, 8'h31);
        en = 14'h2021;
        settle();
        `CHK("keyPullupEn", en, keyPullupEn)
        `CHK("keySampled", keyIn & en, keySampled)
        `CHK("keySampleStrobe", 1'b1, keySampleStrobe)
        rd(ADDR_STATUS, 8'h08);
        wr(ADDR_CTRL, 8'h00);
        keyIn <= ~keyIn;
        wr(ADDR_SETUP_BASE + 32'd5, 8'h20);
        settle();
        `CHK("keyPullupEn", 14'h0, keyPullupEn)
        `CHK("keySampled", keyIn & 14'h2001, keySampled)
        wr(ADDR_SETUP_BASE + 32'd5, 8'h21);
        settle();
        `CHK("keySampled", keyIn & en, keySampled)
        for (int w = 0; w < 4; w++) begin
            cfg = {2'b00, 2'(w), 2'(w), 2'b11};
            keyIn <= ~keyIn;
            wr(ADDR_CTRL, cfg);
            len = 0;
            while (keyPullupEn === 14'h0 && len < 10) begin
                @(posedge clk);
                #1;
                len++;
            end
            `CHK("keyPullupEn", en, keyPullupEn)
            len = 0;
            last = 0;
            strobes = 0;
            while (keyPullupEn !== 14'h0 && len < 50000) begin
                @(posedge clk);
                #1;
                len++;
                if (keySampleStrobe === 1'b1) begin
                    strobes++;
                    last = len;
                    `CHK("keySampled", keyIn & en, keySampled)
                end
            end
            win = (4 << w) * LS_DIV;
            `CHK("windowLen", 1'b1, len >= win - LS_DIV && len <= win + 3)
            `CHK("sampleCount", 32'd1, strobes)
            `CHK("sampleLead", 1'b1, len - last >= LS_DIV - 3 && len - last <= LS_DIV + 3)
            orAcc = '0;
            repeat (2000) begin
                @(posedge clk);
                #1;
                orAcc = orAcc | keyPullupEn;
            end
            `CHK("gapPull", 14'h0, orAcc)
            rd(ADDR_STATUS, 8'h0A);
            rd(ADDR_CTRL, cfg);
            wr(ADDR_CTRL, 8'h00);
        end
        // Stopped low-speed clock: window freezes open, no sample point ever comes
        wr(ADDR_LSCTRL, 8'h00);
        rd(ADDR_LSCTRL, 8'h00);
        wr(ADDR_CTRL, 8'h03);
        wr(ADDR_SETUP_BASE + 32'd5, 8'h20);
        wr(ADDR_SETUP_BASE + 32'd5, 8'h21);
        rd(ADDR_STATUS, 8'h03);
        strobes = 0;
        repeat (2000) begin
            @(posedge clk);
            #1;
            if (keySampleStrobe !== 1'b0) strobes++;
        end
        `CHK("frozenSamples", 32'd0, strobes)
        `CHK("keyPullupEn", en, keyPullupEn)
        `CHK("levelCondConflict", 1'b0, levelCondConflict)
        wr(ADDR_SETUP_BASE + 32'd5, 8'h01);
        settle();
        `CHK("levelCondConflict", 1'b1, levelCondConflict)
        results();
    end
endmodule
